//--- logic/mtfe_pkg.sv
`default_nettype none
package mtfe_pkg;
  localparam logic [7:0] MTFE_CTRL_OFS = 8'h00;
  localparam logic [7:0] MTFE_WMARK_OFS = 8'h04;
  localparam logic [7:0] MTFE_STATUS_OFS = 8'h08;
  localparam logic [7:0] MTFE_TXLAST_OFS = 8'h0c;
  localparam int MTFE_ST_COLLISION_TEST_ERROR = 0;
  localparam int MTFE_ST_ERR = 1;
  localparam logic [6:0] MTFE_CTRL_RST = 7'h00;
  localparam logic [5:0] MTFE_WM_RST = 6'h28;
  localparam int MTFE_CLK_NS = 40;
  localparam int MTFE_BIT_NS = 100;
  localparam logic [6:0] MTFE_CLK_STEP = 7'(MTFE_CLK_NS);
  localparam logic [6:0] MTFE_BIT_STEP = 7'(MTFE_BIT_NS);
  localparam logic [7:0] MTFE_DEPTH = 8'h80;
  localparam logic [10:0] MTFE_PRE_LAST = 11'd63;
  localparam logic [10:0] MTFE_SFD_TAIL = 11'd62;
  localparam logic [10:0] MTFE_PAD_LAST = 11'd543;
  localparam logic [10:0] MTFE_SLOT_BITS = 11'd512;
  localparam logic [8:0] MTFE_FCS_LAST = 9'd31;
  localparam logic [8:0] MTFE_JAM_LAST = 9'd31;
  localparam logic [8:0] MTFE_SQE_LAST = 9'd39;
  localparam logic [8:0] MTFE_SLOT_LAST = 9'd511;
  localparam logic [4:0] MTFE_LAST_TRY = 5'd15;
  localparam logic [4:0] MTFE_BO_LIMIT = 5'd10;
  localparam logic [6:0] MTFE_LOCK_BYTES = 7'd64;
  localparam logic [31:0] MTFE_CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] MTFE_CRC_INIT = 32'hffffffff;
  localparam logic [15:0] MTFE_LFSR_SEED = 16'hace1;
  localparam logic [7:0] MTFE_TXSP_BYTES [4] = '{8'h04, 8'h10, 8'h40, 8'h70};
  localparam logic [7:0] MTFE_TXFW_FREE [4] = '{8'h10, 8'h20, 8'h40, 8'h60};
  localparam logic [7:0] MTFE_RXFW_BYTES [4] = '{8'h10, 8'h20, 8'h40, 8'h70};

  typedef enum logic [3:0] {
    MTFE_IDLE = 4'b0000, MTFE_PRE = 4'b0001, MTFE_DATA = 4'b0010,
    MTFE_PAD = 4'b0011, MTFE_FCS = 4'b0100, MTFE_JAM = 4'b0101,
    MTFE_BACK = 4'b0110, MTFE_SKIP = 4'b0111, MTFE_SQE = 4'b1000,
    MTFE_DONE = 4'b1001
  } mtfe_state_e;

  typedef struct packed {
    logic crc_add;
    logic buf_end;
    logic eop;
    logic sop;
    logic [7:0] data;
  } mtfe_txent_s;

  typedef struct packed {
    logic retry_error;
    logic carrier_loss;
    logic late_collision;
    logic underflow;
    logic [4:0] attempts;
  } mtfe_dstat_s;

  typedef struct packed {
    logic tp_mode;
    logic bcast_disable;
    logic rx_strip_enable;
    logic promiscuous_enable;
    logic retry_disable;
    logic tx_crc_disable;
    logic auto_pad_enable;
  } mtfe_ctrl_s;
endpackage
`default_nettype wire

//--- logic/mtfe_tx_engine.sv
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module mtfe_tx_engine
  import mtfe_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // transmit fifo fill from buffer manager
  input wire mtfe_txent_s tx_in,
  input wire logic tx_in_valid,
  output logic tx_in_ready,
  output logic tx_data_request,
  // descriptor write-back
  output mtfe_dstat_s desc_status,
  output logic desc_status_we,
  output logic desc_own_release,
  // medium
  output logic tx_en,
  output logic tx_data,
  input wire logic col,
  input wire logic crs,
  input wire logic jabber,
  input wire logic link_fail,
  // receive side controls
  input wire logic rx_min_ok,
  input wire logic rx_addr_match,
  input wire logic rx_broadcast,
  input wire logic [7:0] rx_fifo_level,
  output logic rx_accept,
  output logic rx_dma_start,
  output logic rx_strip_on
);

  ////////////////////////////////////////////////////////////////////////
  mtfe_state_e st_r, st_nxt;
  mtfe_ctrl_s ctrl_r;
  mtfe_txent_s mem [128];
  mtfe_txent_s cur_r;
  mtfe_dstat_s dstat_r;
  logic [5:0] wm_r;
  logic [6:0] acc_r;
  logic [7:0] wr_r, rd_r, fs_r, frames_r;
  logic [10:0] tx_bits_r;
  logic [8:0] cnt_r;
  logic [2:0] bi_r;
  logic [7:0] sh_r;
  logic [31:0] crc_r;
  logic [15:0] lfsr_r;
  logic [9:0] slots_r;
  logic [6:0] bytes_r;
  logic [4:0] att_r;
  logic lock_r, eop_rd_r, add_r, late_r, retry_error_flag_r, uflow_r;
  logic seen_r, lost_r, tpl_r, sqe_seen_r, collision_test_error_r, err_r;
  logic txd_r, ten_r, we_r, rel_r;
  logic dp_wr_r;
  logic [7:0] dp_addr_r;
  logic [31:0] hrdata_r;
  logic load;

  ////////////////////////////////////////////////////////////////////////
  // bit-time enable: 10 Mb/s from 25 MHz, two enables every five clocks
  wire [6:0] acc_sum = acc_r + MTFE_CLK_STEP;
  wire bit_en = acc_sum >= MTFE_BIT_STEP;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r <= 7'h00;
    end else begin
      acc_r <= bit_en ? 7'(acc_sum - MTFE_BIT_STEP) : acc_sum;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit fifo; writes stay behind fs_r until the frame is locked
  wire [7:0] prot = lock_r ? rd_r : fs_r;
  wire [7:0] used = wr_r - prot;
  wire [7:0] free = MTFE_DEPTH - used;
  wire [7:0] avail = wr_r - rd_r;
  wire empty = avail == 8'h00;
  wire wr_fire = tx_in_valid & tx_in_ready;
  wire mtfe_txent_s ent = mem[rd_r[6:0]];
  assign tx_in_ready = free != 8'h00;
  assign tx_data_request = free >= MTFE_TXFW_FREE[wm_r[1:0]];
  wire start_ok = !empty && (frames_r != 8'h00
    || avail >= MTFE_TXSP_BYTES[wm_r[3:2]]);

  always_ff @(posedge hclk) begin
    if (wr_fire) begin
      mem[wr_r[6:0]] <= tx_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  wire sending = st_r == MTFE_PRE || st_r == MTFE_DATA
    || st_r == MTFE_PAD || st_r == MTFE_FCS;
  wire col_hit = col & sending;
  wire early = tx_bits_r < MTFE_SLOT_BITS;
  wire give_up = ctrl_r.retry_disable || att_r == MTFE_LAST_TRY;
  wire byte_end = bit_en && bi_r == 3'h7;
  wire pre_end = bit_en && tx_bits_r == MTFE_PRE_LAST;
  wire need_pad = ctrl_r.auto_pad_enable && tx_bits_r < MTFE_PAD_LAST;
  wire fcs_on = ctrl_r.auto_pad_enable || !ctrl_r.tx_crc_disable || add_r;
  wire rewind = st_r == MTFE_JAM && st_nxt == MTFE_BACK;
  wire enter_pre = st_nxt == MTFE_PRE && st_r != MTFE_PRE;
  wire new_frame = st_r == MTFE_IDLE && start_ok;
  wire done = st_r == MTFE_DONE;
  wire carrier_loss_error = ctrl_r.tp_mode ? tpl_r : (!seen_r || lost_r);
  wire sqe_end = st_r == MTFE_SQE && st_nxt == MTFE_DONE;
  wire collision_test_error_set = sqe_end
    && (ctrl_r.tp_mode ? link_fail : !(sqe_seen_r || col));
  wire frame_err = retry_error_flag_r | late_r | uflow_r | carrier_loss_error;
  wire [3:0] bo_k = att_r > MTFE_BO_LIMIT ? MTFE_BO_LIMIT[3:0] : att_r[3:0];
  wire [10:0] bo_one = 11'h001 << bo_k;
  wire [9:0] bo_mask = 10'(bo_one - 11'h001);
  wire crc_fb = crc_r[31] ^ sh_r[0];
  wire pad_fb = crc_r[31];

  logic bit_val;
  always_comb begin
    case (st_r)
      MTFE_PRE: bit_val = !tx_bits_r[0] || tx_bits_r >= MTFE_SFD_TAIL;
      MTFE_DATA: bit_val = sh_r[0];
      MTFE_PAD: bit_val = 1'b0;
      MTFE_FCS: bit_val = !crc_r[31];
      MTFE_JAM: bit_val = tx_bits_r[0];
      default: bit_val = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_nxt = st_r;
    load = 1'b0;
    case (st_r)
      MTFE_IDLE: begin
        if (start_ok) begin
          st_nxt = MTFE_PRE;
        end
      end
      MTFE_PRE: begin
        if (col) begin
          st_nxt = MTFE_JAM;
        end else if (pre_end) begin
          load = !empty;
          st_nxt = empty ? MTFE_SKIP : MTFE_DATA;
        end
      end
      MTFE_DATA: begin
        if (col) begin
          st_nxt = MTFE_JAM;
        end else if (byte_end) begin
          if (cur_r.eop) begin
            st_nxt = need_pad ? MTFE_PAD : (fcs_on ? MTFE_FCS : MTFE_SQE);
          end else if (empty) begin
            st_nxt = MTFE_SKIP;
          end else begin
            load = 1'b1;
          end
        end
      end
      MTFE_PAD: begin
        if (col) begin
          st_nxt = MTFE_JAM;
        end else if (byte_end && tx_bits_r == MTFE_PAD_LAST) begin
          st_nxt = MTFE_FCS;
        end
      end
      MTFE_FCS: begin
        if (col) begin
          st_nxt = MTFE_JAM;
        end else if (bit_en && cnt_r == MTFE_FCS_LAST) begin
          st_nxt = MTFE_SQE;
        end
      end
      MTFE_JAM: begin
        if (bit_en && cnt_r == MTFE_JAM_LAST) begin
          st_nxt = (late_r || retry_error_flag_r) ? MTFE_SKIP : MTFE_BACK;
        end
      end
      MTFE_BACK: begin
        if (slots_r == 10'h000) begin
          st_nxt = MTFE_PRE;
        end
      end
      MTFE_SKIP: begin
        if (eop_rd_r) begin
          st_nxt = MTFE_DONE;
        end else begin
          load = !empty;
        end
      end
      MTFE_SQE: begin
        if (bit_en && cnt_r == MTFE_SQE_LAST) begin
          st_nxt = MTFE_DONE;
        end
      end
      MTFE_DONE: st_nxt = MTFE_IDLE;
      default: st_nxt = MTFE_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  wire counting = st_r == MTFE_FCS || st_r == MTFE_JAM
    || st_r == MTFE_BACK || st_r == MTFE_SQE;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= MTFE_IDLE;
      cnt_r <= 9'h000;
    end else begin
      st_r <= st_nxt;
      cnt_r <= (st_nxt != st_r) ? 9'h000 : (bit_en && counting) ? 9'(cnt_r + 9'h001) : cnt_r;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_bits_r <= 11'h000;
      bi_r <= 3'h0;
      sh_r <= 8'h00;
      cur_r <= '0;
    end else begin
      if (enter_pre) begin
        tx_bits_r <= 11'h000;
      end else if (bit_en && (sending || st_r == MTFE_JAM) && tx_bits_r != 11'h7ff) begin
        tx_bits_r <= 11'(tx_bits_r + 11'h001);
      end
      bi_r <= (st_r == MTFE_DATA || st_r == MTFE_PAD) ? 3'(bi_r + {2'h0, bit_en}) : 3'h0;
      if (load) begin
        sh_r <= ent.data;
        cur_r <= ent;
      end else if (bit_en && st_r == MTFE_DATA) begin
        sh_r <= {1'b0, sh_r[7:1]};
      end
    end
  end

  // pointers and frame protection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 8'h00;
      rd_r <= 8'h00;
      fs_r <= 8'h00;
      frames_r <= 8'h00;
      lock_r <= 1'b0;
      bytes_r <= 7'h00;
      eop_rd_r <= 1'b0;
      add_r <= 1'b0;
    end else begin
      if (wr_fire) begin
        wr_r <= 8'(wr_r + 8'h01);
      end
      frames_r <= 8'(frames_r + {7'h00, wr_fire & tx_in.eop} - {7'h00, done});
      if (rewind) begin
        rd_r <= fs_r;
      end else if (load) begin
        rd_r <= 8'(rd_r + 8'h01);
      end
      if (done) begin
        fs_r <= rd_r;
      end
      // hold a frame's head until 64 bytes have been loaded; a skip frees it at once
      if (done || rewind) begin
        lock_r <= 1'b0;
        bytes_r <= 7'h00;
      end else if (st_r == MTFE_SKIP || bytes_r == MTFE_LOCK_BYTES) begin
        lock_r <= 1'b1;
      end else if (load) begin
        bytes_r <= 7'(bytes_r + 7'h01);
      end
      if (done || rewind) begin
        eop_rd_r <= 1'b0;
      end else if (load && ent.eop) begin
        eop_rd_r <= 1'b1;
      end
      if (load && ent.sop) begin
        add_r <= ent.crc_add;
      end
    end
  end

  // attempts, frame error flags, backoff
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      att_r <= 5'h00;
      late_r <= 1'b0;
      retry_error_flag_r <= 1'b0;
      uflow_r <= 1'b0;
      slots_r <= 10'h000;
      lfsr_r <= MTFE_LFSR_SEED;
    end else begin
      lfsr_r <= {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
      if (new_frame) begin
        att_r <= 5'h00;
        late_r <= 1'b0;
        retry_error_flag_r <= 1'b0;
        uflow_r <= 1'b0;
      end else begin
        if (col_hit && early) begin
          att_r <= 5'(att_r + 5'h01);
          retry_error_flag_r <= retry_error_flag_r | give_up;
        end
        late_r <= late_r | (col_hit & !early);
        // only a starved preamble or data byte is an underflow, not a jam drain
        uflow_r <= uflow_r | ((st_r == MTFE_PRE || st_r == MTFE_DATA) && st_nxt == MTFE_SKIP && !col);
      end
      if (rewind) begin
        slots_r <= lfsr_r[9:0] & bo_mask;
      end else if (st_r == MTFE_BACK && bit_en && cnt_r == MTFE_SLOT_LAST) begin
        slots_r <= 10'(slots_r - 10'h001);
      end
    end
  end

  // crc: shifted msb-first, so the remainder leaves bit 31 first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      crc_r <= MTFE_CRC_INIT;
    end else if (enter_pre) begin
      crc_r <= MTFE_CRC_INIT;
    end else if (bit_en && st_r == MTFE_DATA) begin
      crc_r <= {crc_r[30:0], 1'b0} ^ (crc_fb ? MTFE_CRC_POLY : 32'h00000000);
    end else if (bit_en && st_r == MTFE_PAD) begin
      crc_r <= {crc_r[30:0], 1'b0} ^ (pad_fb ? MTFE_CRC_POLY : 32'h00000000);
    end else if (bit_en && st_r == MTFE_FCS) begin
      crc_r <= {crc_r[30:0], 1'b1};
    end
  end

  // carrier supervision and collision pair test
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seen_r <= 1'b0;
      lost_r <= 1'b0;
      tpl_r <= 1'b0;
      sqe_seen_r <= 1'b0;
    end else begin
      if (enter_pre) begin
        seen_r <= 1'b0;
        lost_r <= 1'b0;
        tpl_r <= 1'b0;
      end else if (sending) begin
        seen_r <= seen_r | crs;
        lost_r <= lost_r | (seen_r & !crs);
        tpl_r <= tpl_r | jabber | link_fail;
      end
      sqe_seen_r <= st_r == MTFE_SQE && (sqe_seen_r || col);
    end
  end

  // medium pins and descriptor write-back
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd_r <= 1'b0;
      ten_r <= 1'b0;
      we_r <= 1'b0;
      rel_r <= 1'b0;
      dstat_r <= '0;
    end else begin
      if (bit_en) begin
        txd_r <= bit_val;
        ten_r <= sending || st_r == MTFE_JAM;
      end
      we_r <= done;
      rel_r <= st_r == MTFE_SKIP && load && ent.buf_end && !ent.sop;
      if (done) begin
        dstat_r <= '{retry_error: retry_error_flag_r, carrier_loss: carrier_loss_error, late_collision: late_r,
          underflow: uflow_r, attempts: att_r};
      end
    end
  end
  assign tx_data = txd_r;
  assign tx_en = ten_r;
  assign desc_status = dstat_r;
  assign desc_status_we = we_r;
  assign desc_own_release = rel_r;

  ////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, registered read data
  wire ap = hsel & htrans[1] & hready;
  wire w_ctrl = dp_wr_r && dp_addr_r == MTFE_CTRL_OFS;
  wire w_wm = dp_wr_r && dp_addr_r == MTFE_WMARK_OFS;
  wire w_st = dp_wr_r && dp_addr_r == MTFE_STATUS_OFS;
  wire [31:0] st_word = {24'h000000, st_r, 2'b00, err_r, collision_test_error_r};
  wire [31:0] rd_val = haddr[7:0] == MTFE_CTRL_OFS ? {25'h0000000, ctrl_r}
    : haddr[7:0] == MTFE_WMARK_OFS ? {26'h0000000, wm_r}
    : haddr[7:0] == MTFE_STATUS_OFS ? st_word
    : haddr[7:0] == MTFE_TXLAST_OFS ? {23'h000000, dstat_r}
    : 32'h00000000;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r <= 1'b0;
      dp_addr_r <= 8'h00;
      hrdata_r <= 32'h00000000;
    end else begin
      if (hready) begin
        dp_wr_r <= ap & hwrite;
        dp_addr_r <= haddr[7:0];
      end
      if (ap && !hwrite) begin
        hrdata_r <= rd_val;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= MTFE_CTRL_RST;
      wm_r <= MTFE_WM_RST;
      collision_test_error_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      if (w_ctrl) begin
        ctrl_r <= hwdata[6:0];
      end
      if (w_wm) begin
        wm_r <= hwdata[5:0];
      end
      // set wins over a write-one clear in the same cycle
      collision_test_error_r <= collision_test_error_set | (collision_test_error_r & !(w_st & hwdata[MTFE_ST_COLLISION_TEST_ERROR]));
      err_r <= collision_test_error_set | (done & frame_err)
        | (err_r & !(w_st & hwdata[MTFE_ST_ERR]));
    end
  end
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_r;

  ////////////////////////////////////////////////////////////////////////
  // receive programming
  assign rx_accept = rx_min_ok & (ctrl_r.promiscuous_enable
    | rx_addr_match | (rx_broadcast & !ctrl_r.bcast_disable));
  assign rx_dma_start = rx_fifo_level >= MTFE_RXFW_BYTES[wm_r[5:4]];
  assign rx_strip_on = ctrl_r.rx_strip_enable;

  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_wm_reset_value: assert property (!$past(hresetn) |-> wm_r == MTFE_WM_RST)
    else $error("watermarks not at reset value");
  a_pad_to_min: assert property ((st_r == MTFE_PAD && st_nxt == MTFE_FCS) |-> tx_bits_r == MTFE_PAD_LAST)
    else $error("pad ended off the minimum bit count");
  a_pad_zero_bits: assert property ((st_r == MTFE_PAD && bit_en) |=> !tx_data)
    else $error("pad bit not zero");
  a_autopad_fcs: assert property ((st_r == MTFE_DATA && byte_end && !col && cur_r.eop
    && ctrl_r.auto_pad_enable) |=> st_r == MTFE_PAD || st_r == MTFE_FCS)
    else $error("auto pad frame without fcs");
  a_fcs_default_on: assert property ((st_r == MTFE_DATA && byte_end && !col && cur_r.eop
    && !need_pad && !ctrl_r.tx_crc_disable) |=> st_r == MTFE_FCS)
    else $error("fcs not appended");
  a_fcs_msb_first: assert property ((st_r == MTFE_FCS && bit_en) |=> tx_data == !$past(crc_r[31]))
    else $error("fcs bit order wrong");
  a_start_whole: assert property ((st_r == MTFE_IDLE && frames_r != 8'h00 && !empty) |=> st_r == MTFE_PRE)
    else $error("buffered frame did not start");
  a_start_hold: assert property ((st_r == MTFE_IDLE && !start_ok) |=> st_r == MTFE_IDLE)
    else $error("started below start point");
  a_early_retry: assert property ((st_r == MTFE_JAM && bit_en && cnt_r == MTFE_JAM_LAST
    && !late_r && !retry_error_flag_r) |=> st_r == MTFE_BACK ##1 rd_r == fs_r)
    else $error("early collision not retried");
  a_retry_limit: assert property ((col_hit && early && att_r == MTFE_LAST_TRY) |=> retry_error_flag_r)
    else $error("retry error not flagged");
  a_late_abandon: assert property ((col_hit && !early) |=> late_r ##0 (st_r == MTFE_JAM)[*2])
    else $error("late collision not handled");
  a_frame_protect: assert property (!lock_r |-> 8'(wr_r - fs_r) <= MTFE_DEPTH)
    else $error("protected frame overwritten");
  a_collision_test_error_summary: assert property (collision_test_error_set |=> collision_test_error_r && err_r)
    else $error("collision test error not recorded");
  a_promiscuous_enable_accept: assert property ((ctrl_r.promiscuous_enable && rx_min_ok) |-> rx_accept)
    else $error("promiscuous frame refused");

  c_retry: cover property (st_r == MTFE_BACK ##[1:1000] st_r == MTFE_PRE);
  c_padded: cover property (st_r == MTFE_PAD ##1 st_r == MTFE_FCS);
  c_late: cover property (col_hit && !early);
  c_release: cover property (desc_own_release);

endmodule // mtfe_tx_engine
`default_nettype wire

//--- verification/mtfe_medium_model.sv
`timescale 1ns/1ns
`default_nettype none
module mtfe_medium_model (
  // clock
  input wire logic hclk,
  // from transmitter and testbench
  input wire logic tx_en,
  input wire logic sqe_on,
  input wire logic col_inj,
  // to transmitter
  output logic crs,
  output logic col,
  output logic jabber,
  output logic link_fail
);
  logic crs_r = 1'b0;
  logic [6:0] gap_r = 7'h7f;
  assign jabber = 1'b0;
  assign link_fail = 1'b0;
  assign crs = crs_r;
  ////////////////////////////////////////////////////////////
  // carrier follows our own transmission one clock late
  always_ff @(posedge hclk) crs_r <= tx_en;
  always_ff @(posedge hclk) begin
    if (tx_en) gap_r <= 7'h00;
    else if (gap_r != 7'h7f) gap_r <= gap_r + 7'h01;
  end
  // sqe burst 20..39 clocks after idle, well inside the 40 bit window
  // col_inj is a collision from another station while we send
  assign col = (sqe_on && !tx_en && gap_r >= 7'h14 && gap_r < 7'h28) || col_inj;
endmodule // mtfe_medium_model
`default_nettype wire

//--- verification/mac_tx_frame_engine_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module mac_tx_frame_engine_tb_top;
  import mtfe_pkg::*;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, tx_in_valid = 0, sqe_on = 1, col_inj = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic [1:0] htrans = 0;
  logic [6:0] c;
  mtfe_txent_s tx_in = '0;
  mtfe_dstat_s desc_status;
  logic hreadyout, hresp, tx_in_ready, tx_data_request, desc_status_we, desc_own_release;
  logic tx_en, tx_data, col, crs, jabber, link_fail, rx_accept, rx_dma_start, rx_strip_on;
  logic rx_min_ok = 0, rx_addr_match = 0, rx_broadcast = 0;
  logic [7:0] rx_fifo_level = 0;
  int n_mismatch = 0, n_tests = 0, seed = 17607, en_cnt = 0, k, col_at = 0;
  mtfe_tx_engine i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .tx_in, .tx_in_valid, .tx_in_ready, .tx_data_request,
    .desc_status, .desc_status_we, .desc_own_release, .tx_en, .tx_data, .col, .crs, .jabber, .link_fail,
    .rx_min_ok, .rx_addr_match, .rx_broadcast, .rx_fifo_level, .rx_accept, .rx_dma_start, .rx_strip_on);
  mtfe_medium_model i_medium (.hclk, .tx_en, .sqe_on, .col_inj, .crs, .col, .jabber, .link_fail);
  ////////////////////////////////////////////////////////////
  initial forever #20 hclk = ~hclk;
  // one-clock collision once tx_en has been high for col_at clocks
  always @(posedge hclk) begin
    if (tx_en === 1'b1) en_cnt++;
    col_inj <= col_at > 0 && en_cnt == col_at;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // one single transfer; entered right after a rising edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    logic r;
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do begin @(negedge hclk); r = hreadyout; @(posedge hclk); end while (!r);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(negedge hclk); r = hreadyout; q = hrdata; @(posedge hclk); end while (!r);
  endtask
  function automatic logic [31:0] exp_acc(input logic [6:0] m, input logic ok, a, b);
    return 32'(ok & (m[3] | a | (b & !m[5])));
  endfunction
  // feed a whole frame, then judge length on the wire and status
  task automatic frame(input int n, input logic [6:0] m, input logic ca, input int bits, input logic [8:0] est,
    input int cat);
    logic r;
    int tol;
    tol = (cat != 0) ? 8 : 3;
    ahb(1, MTFE_CTRL_OFS, {25'h0, m}, rd);
    en_cnt = 0;
    col_at = cat;
    for (int i = 0; i < n; i++) begin
      tx_in <= '{crc_add: ca, buf_end: i == n - 1, eop: i == n - 1, sop: i == 0, data: 8'($random(seed))};
      tx_in_valid <= 1;
      do begin @(negedge hclk); r = tx_in_ready; @(posedge hclk); end while (!r);
    end
    tx_in_valid <= 0;
    for (k = 0; k < 4000 && desc_status_we !== 1'b1; k++) @(negedge hclk);
    chk(32'(k < 4000), 1);
    col_at = 0;
    chk(32'(desc_status[8:5]), 32'(est[8:5]));
    chk(32'(desc_status[4:0]), 32'(est[4:0]));
    // bit enables run 2 per 5 clocks, so allow a few clocks of slack
    chk(32'(en_cnt >= bits * 5 / 2 - tol && en_cnt <= bits * 5 / 2 + tol), 1);
    @(posedge hclk);
    $display("test frame of %0d bytes done", n);
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    @(posedge hclk);
    chk(32'(tx_data_request), 1);
    ahb(0, MTFE_CTRL_OFS, 0, rd);
    chk(rd, 32'h0);
    ahb(0, MTFE_WMARK_OFS, 0, rd);
    chk(rd, 32'h28);
    ahb(1, 8'h40, 32'hffffffff, rd);
    ahb(0, 8'h40, 0, rd);
    chk(rd, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 16; i++) begin
      c = 7'($random(seed)) & 7'h38;
      ahb(1, MTFE_CTRL_OFS, {25'h0, c}, rd);
      {rx_min_ok, rx_addr_match, rx_broadcast} <= 3'($random(seed));
      rx_fifo_level <= 8'($random(seed));
      @(negedge hclk);
      chk(32'(rx_accept), exp_acc(c, rx_min_ok, rx_addr_match, rx_broadcast));
      chk(32'(rx_dma_start), 32'(rx_fifo_level >= 8'h40));
      chk(32'(rx_strip_on), 32'(c[4]));
      @(posedge hclk);
    end
    $display("test receive controls done");
    frame(20, 7'h03, 0, 576, 9'h000, 0);
    frame(10, 7'h00, 0, 176, 9'h000, 0);
    frame(80, 7'h02, 0, 704, 9'h000, 0);
    frame(80, 7'h02, 1, 736, 9'h000, 0);
    ahb(0, MTFE_STATUS_OFS, 0, rd);
    chk(rd & 32'h3, 32'h0);
    sqe_on <= 0;
    frame(10, 7'h00, 0, 176, 9'h000, 0);
    ahb(0, MTFE_STATUS_OFS, 0, rd);
    chk(rd & 32'h3, 32'h3);
    sqe_on <= 1;
    ahb(1, MTFE_STATUS_OFS, 32'h3, rd);
    ahb(0, MTFE_STATUS_OFS, 0, rd);
    chk(rd & 32'h3, 32'h0);
    $display("test collision test error done");
    frame(10, 7'h00, 0, 248, 9'h001, 100);
    frame(10, 7'h04, 0, 72, 9'h101, 100);
    frame(80, 7'h02, 0, 632, 9'h040, 1500);
    conclude();
  end
  initial begin
    #(40 * 40000);
    n_mismatch++;
    conclude();
  end
endmodule // mac_tx_frame_engine_tb_top
`default_nettype wire
